// *** core/timer_clock_select.sv ***
/*
  Timer clock selection: the clock select register, the shared timer 0/1
  prescaler, pin event detection and the per-timer count-enable ticks.
  Assumes the timers run on clk_sys_i and advance once per tick pulse, and
  that the counter-select, split and external-clock choice inputs come from
  registers on the same clock.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module timer_clock_select #(
  parameter int DIV12 = timer_clock_select_pkg::DIV_SYS12,
  parameter int DIV4  = timer_clock_select_pkg::DIV_SYS4,
  parameter int DIV8  = timer_clock_select_pkg::DIV_EXT8
) (
  input  wire logic                                      clk_sys_i,
  input  wire logic                                      reset_n_i,
  // Register port
  input  wire logic [timer_clock_select_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [timer_clock_select_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                                      reg_we_i,
  input  wire logic                                      reg_re_i,
  output logic      [timer_clock_select_pkg::DATA_W-1:0] reg_rdata_o,
  // Timer configuration held elsewhere
  input  wire logic                                      timer0_counter_sel_i,
  input  wire logic                                      timer1_counter_sel_i,
  input  wire logic                                      timer2_split_i,
  input  wire logic                                      timer3_split_i,
  input  wire logic                                      timer2_ext_clk_choice_i,
  input  wire logic                                      timer3_ext_clk_choice_i,
  // Asynchronous pins
  input  wire logic                                      timer0_pin_i,
  input  wire logic                                      timer1_pin_i,
  input  wire logic                                      ext_clk_i,
  // Count-enable ticks and register contents
  output logic                                           timer0_tick_o,
  output logic                                           timer1_tick_o,
  output logic                                           timer2_low_tick_o,
  output logic                                           timer2_high_tick_o,
  output logic                                           timer3_low_tick_o,
  output logic                                           timer3_high_tick_o,
  output logic      [timer_clock_select_pkg::DATA_W-1:0] clk_sel_o
);

  localparam int DW = timer_clock_select_pkg::DATA_W;
  localparam int PW = timer_clock_select_pkg::PRESCALE_W;

  if (DW <= timer_clock_select_pkg::BIT_T3_HIGH) begin : g_bad_data_w
    $error("timer_clock_select data width too narrow for the control register");
  end

  typedef struct packed {
    logic [DW-1:0] ctrl;
    logic [DW-1:0] status;
    logic [DW-1:0] rdata;
    logic          t0_tick;
    logic          t1_tick;
    logic          t2_low_tick;
    logic          t2_high_tick;
    logic          t3_low_tick;
    logic          t3_high_tick;
  } state_t;

  state_t q;
  state_t d;

  // Source reported for a timer; timers 2 and 3 pass no pin select
  function automatic timer_clock_select_pkg::src_t src_of(
    input logic counter_sel,
    input logic sys_sel
  );
    timer_clock_select_pkg::src_t src;
    src = timer_clock_select_pkg::SRC_ALT;
    if (counter_sel) begin
      src = timer_clock_select_pkg::SRC_PIN;
    end else if (sys_sel) begin
      src = timer_clock_select_pkg::SRC_SYS;
    end
    return src;
  endfunction : src_of

  // Pin synchronisers and edge detectors
  logic [timer_clock_select_pkg::PIN_COUNT-1:0] pin_async;
  logic [timer_clock_select_pkg::PIN_COUNT-1:0] pin_rise;
  logic [timer_clock_select_pkg::PIN_COUNT-1:0] pin_fall;

  assign pin_async[timer_clock_select_pkg::PIN_T0]  = timer0_pin_i;
  assign pin_async[timer_clock_select_pkg::PIN_T1]  = timer1_pin_i;
  assign pin_async[timer_clock_select_pkg::PIN_EXT] = ext_clk_i;

  pin_sync #(
    .WIDTH (timer_clock_select_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_async),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // Shared prescaler and the alternative clocks of timers 2 and 3
  prescale_if ps ();

  assign ps.prescale_sel = q.ctrl[timer_clock_select_pkg::PRESCALE_LSB +: PW];

  clock_prescaler #(
    .DIV12 (DIV12),
    .DIV4  (DIV4),
    .DIV8  (DIV8)
  ) u_prescaler (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .ext_rise_i (pin_rise[timer_clock_select_pkg::PIN_EXT]),
    .ps         (ps)
  );

  // Control bits
  logic sel_t3_high;
  logic sel_t3_low;
  logic sel_t2_high;
  logic sel_t2_low;
  logic sel_t1;
  logic sel_t0;

  assign sel_t3_high = q.ctrl[timer_clock_select_pkg::BIT_T3_HIGH];
  assign sel_t3_low  = q.ctrl[timer_clock_select_pkg::BIT_T3_LOW];
  assign sel_t2_high = q.ctrl[timer_clock_select_pkg::BIT_T2_HIGH];
  assign sel_t2_low  = q.ctrl[timer_clock_select_pkg::BIT_T2_LOW];
  assign sel_t1      = q.ctrl[timer_clock_select_pkg::BIT_T1];
  assign sel_t0      = q.ctrl[timer_clock_select_pkg::BIT_T0];

  // Alternative clock of timers 2 and 3: external /8 or system /12
  logic t2_alt_tick;
  logic t3_alt_tick;

  assign t2_alt_tick = timer2_ext_clk_choice_i ? ps.tick_ext8 : ps.tick_div12;
  assign t3_alt_tick = timer3_ext_clk_choice_i ? ps.tick_ext8 : ps.tick_div12;

  // Register decode; no page input exists, so the address alone selects
  logic hit_clk_sel;
  logic hit_status;

  assign hit_clk_sel = (reg_addr_i == timer_clock_select_pkg::ADDR_CLK_SEL);
  assign hit_status  = (reg_addr_i == timer_clock_select_pkg::ADDR_TICK_STATUS);

  always_comb begin
    d = q;

    // Software write; the status register is read-only
    if (reg_we_i && hit_clk_sel) begin
      d.ctrl = reg_wdata_i;
    end

    // Read data stand only in the cycle after the read strobe
    d.rdata = timer_clock_select_pkg::READ_IDLE;
    if (reg_re_i) begin
      if (hit_clk_sel) begin
        d.rdata = q.ctrl;
      end else if (hit_status) begin
        d.rdata = q.status;
      end
    end

    // Timer 0: pin events override the clock select
    if (timer0_counter_sel_i) begin
      d.t0_tick = pin_fall[timer_clock_select_pkg::PIN_T0];
    end else if (sel_t0) begin
      d.t0_tick = 1'b1;
    end else begin
      d.t0_tick = ps.tick_pre;
    end

    // Timer 1: pin events override the clock select
    if (timer1_counter_sel_i) begin
      d.t1_tick = pin_fall[timer_clock_select_pkg::PIN_T1];
    end else if (sel_t1) begin
      d.t1_tick = 1'b1;
    end else begin
      d.t1_tick = ps.tick_pre;
    end

    // Timer 2: low byte, or whole timer in 16-bit mode
    d.t2_low_tick = sel_t2_low ? 1'b1 : t2_alt_tick;

    // Timer 2 high byte only ticks on its own in split mode
    d.t2_high_tick = 1'b0;
    if (timer2_split_i) begin
      d.t2_high_tick = sel_t2_high ? 1'b1 : t2_alt_tick;
    end

    // Timer 3: low byte, or whole timer in 16-bit mode
    d.t3_low_tick = sel_t3_low ? 1'b1 : t3_alt_tick;

    // Timer 3 high byte only ticks on its own in split mode
    d.t3_high_tick = 1'b0;
    if (timer3_split_i) begin
      d.t3_high_tick = sel_t3_high ? 1'b1 : t3_alt_tick;
    end

    // Source in use by each timer, for software to read back
    d.status = '0;
    d.status[timer_clock_select_pkg::ST_T0 +: 2] = src_of(timer0_counter_sel_i, sel_t0);
    d.status[timer_clock_select_pkg::ST_T1 +: 2] = src_of(timer1_counter_sel_i, sel_t1);
    d.status[timer_clock_select_pkg::ST_T2 +: 2] = src_of(1'b0, sel_t2_low);
    d.status[timer_clock_select_pkg::ST_T3 +: 2] = src_of(1'b0, sel_t3_low);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q              <= '0;
      q.ctrl         <= timer_clock_select_pkg::CLK_SEL_RESET;
      q.rdata        <= timer_clock_select_pkg::READ_IDLE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o        = q.rdata;
  assign clk_sel_o          = q.ctrl;
  assign timer0_tick_o      = q.t0_tick;
  assign timer1_tick_o      = q.t1_tick;
  assign timer2_low_tick_o  = q.t2_low_tick;
  assign timer2_high_tick_o = q.t2_high_tick;
  assign timer3_low_tick_o  = q.t3_low_tick;
  assign timer3_high_tick_o = q.t3_high_tick;

endmodule : timer_clock_select
`default_nettype wire

// *** core/timer_clock_select_pkg.sv ***
/*
  Shared constants and types of the timer clock selection block: register
  addresses, field positions, reset value, prescale codes and divide ratios.
  Assumes nothing of its surroundings.
*/
package timer_clock_select_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 8;

  localparam logic [ADDR_W-1:0] ADDR_CLK_SEL     = 8'h8E;
  localparam logic [ADDR_W-1:0] ADDR_TICK_STATUS = 8'h9E;

  localparam logic [DATA_W-1:0] CLK_SEL_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE        = 8'h00;

  localparam int BIT_T3_HIGH  = 7;
  localparam int BIT_T3_LOW   = 6;
  localparam int BIT_T2_HIGH  = 5;
  localparam int BIT_T2_LOW   = 4;
  localparam int BIT_T1       = 3;
  localparam int BIT_T0       = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W   = 2;

  localparam logic [PRESCALE_W-1:0] PRESCALE_SYS12  = 2'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_SYS4_A = 2'h1;
  localparam logic [PRESCALE_W-1:0] PRESCALE_SYS4_B = 2'h2;
  localparam logic [PRESCALE_W-1:0] PRESCALE_EXT8   = 2'h3;

  localparam int DIV_SYS12 = 12;
  localparam int DIV_SYS4  = 4;
  localparam int DIV_EXT8  = 8;

  localparam int PIN_COUNT = 3;
  localparam int PIN_T0    = 0;
  localparam int PIN_T1    = 1;
  localparam int PIN_EXT   = 2;

  localparam int ST_T0 = 0;
  localparam int ST_T1 = 2;
  localparam int ST_T2 = 4;
  localparam int ST_T3 = 6;

  typedef enum logic [1:0] {
    SRC_SYS = 2'h0,
    SRC_ALT = 2'h1,
    SRC_PIN = 2'h3
  } src_t;

endpackage : timer_clock_select_pkg

// *** core/prescale_if.sv ***
/*
  Carrier between the main block and the prescaler: the prescale choice and
  the one-cycle tick pulses. Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
  logic [timer_clock_select_pkg::PRESCALE_W-1:0] prescale_sel;
  logic                                          tick_div12;
  logic                                          tick_div4;
  logic                                          tick_ext8;
  logic                                          tick_pre;

  modport source (
    input  prescale_sel,
    output tick_div12,
    output tick_div4,
    output tick_ext8,
    output tick_pre
  );

  modport sink (
    output prescale_sel,
    input  tick_div12,
    input  tick_div4,
    input  tick_ext8,
    input  tick_pre
  );
endinterface : prescale_if
`default_nettype wire

// *** core/pin_sync.sv ***
/*
  Two-flop synchroniser with a two-sample level filter and edge pulses for
  a group of asynchronous pins. Assumes pins are held two system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = timer_clock_select_pkg::PIN_COUNT
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one pin");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] hist;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } state_t;

  state_t q;
  state_t d;

  always_comb begin
    d      = q;
    d.meta = async_i;
    d.sync = q.meta;
    d.hist = q.sync;
    // Level follows the pin only after two equal samples
    d.level = (~(q.sync ^ q.hist) & q.sync) | ((q.sync ^ q.hist) & q.level);
    d.rise  = d.level & ~q.level;
    d.fall  = ~d.level & q.level;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_o = q.rise;
  assign fall_o = q.fall;
endmodule : pin_sync
`default_nettype wire

// *** core/clock_prescaler.sv ***
/*
  Free-running dividers for the timer ticks: system clock by twelve and by
  four, and counted external clock edges by eight. Assumes ext_rise_i is a
  synchronised one-cycle pulse per external clock rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler #(
  parameter int DIV12 = timer_clock_select_pkg::DIV_SYS12,
  parameter int DIV4  = timer_clock_select_pkg::DIV_SYS4,
  parameter int DIV8  = timer_clock_select_pkg::DIV_EXT8
) (
  input  wire logic     clk_sys_i,
  input  wire logic     reset_n_i,
  input  wire logic     ext_rise_i,
  prescale_if.source    ps
);
  if (DIV12 < 2 || DIV4 < 2 || DIV8 < 2) begin : g_bad_div
    $error("clock_prescaler divide ratios must be at least two");
  end

  localparam int W12 = $clog2(DIV12);
  localparam int W4  = $clog2(DIV4);
  localparam int W8  = $clog2(DIV8);

  typedef struct packed {
    logic [W12-1:0] cnt12;
    logic [W4-1:0]  cnt4;
    logic [W8-1:0]  cnt8;
    logic           t12;
    logic           t4;
    logic           t8;
    logic           tpre;
  } state_t;

  state_t q;
  state_t d;

  always_comb begin
    d       = q;
    d.t12   = (q.cnt12 == W12'(DIV12 - 1));
    d.cnt12 = d.t12 ? '0 : q.cnt12 + W12'(1);
    d.t4    = (q.cnt4 == W4'(DIV4 - 1));
    d.cnt4  = d.t4 ? '0 : q.cnt4 + W4'(1);
    d.t8    = 1'b0;
    if (ext_rise_i) begin
      d.t8   = (q.cnt8 == W8'(DIV8 - 1));
      d.cnt8 = d.t8 ? '0 : q.cnt8 + W8'(1);
    end
    case (ps.prescale_sel)
      timer_clock_select_pkg::PRESCALE_SYS12:  d.tpre = d.t12;
      timer_clock_select_pkg::PRESCALE_SYS4_A: d.tpre = d.t4;
      timer_clock_select_pkg::PRESCALE_SYS4_B: d.tpre = d.t4;
      timer_clock_select_pkg::PRESCALE_EXT8:   d.tpre = d.t8;
      default:                                 d.tpre = d.t12;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ps.tick_div12 = q.t12;
  assign ps.tick_div4  = q.t4;
  assign ps.tick_ext8  = q.t8;
  assign ps.tick_pre   = q.tpre;
endmodule : clock_prescaler
`default_nettype wire

// *** verification/timer_clock_select_sva.sv ***
/*
  Checker for the timer clock selection block: tick selection, register
  port timing and prescaler period. Assumes one clock and async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_clock_select_sva (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_we_i,
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       timer0_counter_sel_i,
  input wire logic       timer1_counter_sel_i,
  input wire logic       timer2_split_i,
  input wire logic       timer3_split_i,
  input wire logic       timer1_pin_i,
  input wire logic       timer0_tick_o,
  input wire logic       timer1_tick_o,
  input wire logic       timer2_low_tick_o,
  input wire logic       timer2_high_tick_o,
  input wire logic       timer3_low_tick_o,
  input wire logic       timer3_high_tick_o,
  input wire logic [7:0] clk_sel_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic c4;
  assign c4 = (clk_sel_o[2:0] == 3'h1) && !timer0_counter_sel_i;

  a_t0_sys_tick: assert property (
    clk_sel_o[2] && !timer0_counter_sel_i |=> timer0_tick_o) else $error("timer 0 tick missing");
  a_t1_sys_tick: assert property (
    clk_sel_o[3] && !timer1_counter_sel_i |=> timer1_tick_o) else $error("timer 1 tick missing");
  a_t2_low_sys: assert property (clk_sel_o[4] |=> timer2_low_tick_o)
    else $error("timer 2 low tick missing");
  a_t2_high_off: assert property (!timer2_split_i |=> !timer2_high_tick_o)
    else $error("timer 2 high tick outside split mode");
  a_t3_high_sys: assert property (
    clk_sel_o[7] && timer3_split_i |=> timer3_high_tick_o) else $error("timer 3 high tick missing");
  a_t3_low_sys: assert property (clk_sel_o[6] |=> timer3_low_tick_o)
    else $error("timer 3 low tick missing");
  a_div4_period: assert property (
    timer0_tick_o && $past(c4) ##0 c4 [*4] |=> timer0_tick_o) else $error("divide by four late");
  a_t1_pin_quiet: assert property (
    (timer1_counter_sel_i && $stable(timer1_pin_i)) [*8] |=> !timer1_tick_o)
    else $error("timer 1 ticked without a pin edge");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_read_value: assert property (
    reg_re_i && reg_addr_i == 8'h8E |=> reg_rdata_o == $past(clk_sel_o)) else $error("bad read");
  a_write_takes: assert property (
    reg_we_i && reg_addr_i == 8'h8E |=> clk_sel_o == $past(reg_wdata_i)) else $error("bad write");
endmodule : timer_clock_select_sva

bind timer_clock_select timer_clock_select_sva u_sva (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .timer0_counter_sel_i(timer0_counter_sel_i),
  .timer1_counter_sel_i(timer1_counter_sel_i), .timer2_split_i(timer2_split_i),
  .timer3_split_i(timer3_split_i), .timer1_pin_i(timer1_pin_i),
  .timer0_tick_o(timer0_tick_o), .timer1_tick_o(timer1_tick_o),
  .timer2_low_tick_o(timer2_low_tick_o), .timer2_high_tick_o(timer2_high_tick_o),
  .timer3_low_tick_o(timer3_low_tick_o), .timer3_high_tick_o(timer3_high_tick_o),
  .clk_sel_o(clk_sel_o));
`default_nettype wire

// *** verification/timer_bank_model.sv ***
/*
  Model of the four timers seen as tick counters, one per tick output.
  Assumes ticks are one-cycle count enables on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_bank_model (
  input  wire logic            clk_sys_i,
  input  wire logic            reset_n_i,
  input  wire logic            clear_i,
  input  wire logic [5:0]      tick_i,
  output logic      [5:0][7:0] count_o
);
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= '0;
    end else begin
      for (int k = 0; k < 6; k++) begin
        count_o[k] <= count_o[k] + {7'h00, tick_i[k]};
      end
    end
  end
endmodule : timer_bank_model
`default_nettype wire

// *** verification/tb_timer_clock_select.sv ***
/*
  Testbench: a table of selections counted over 96 cycles, then register,
  pin counting and mid-run reset cases. Assumes a 125 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_timer_clock_select;
  typedef struct packed {
    logic [7:0]      ctrl;
    logic [5:0]      cfg;
    logic [5:0][7:0] exp;
  } row_t;
  logic            clk_sys_i, reset_n_i, reg_we_i, reg_re_i, clr, pin0, pin1, ext_clk;
  logic [7:0]      reg_addr_i, reg_wdata_i, reg_rdata_o, clk_sel_o;
  logic [5:0]      cfg, ticks;
  logic [5:0][7:0] counts;
  int              num_errors = 0;
  int              num_checks = 0;
  // Rows: ctrl, {xchoice3, xchoice2, split3, split2, ctsel1, ctsel0}, counts t3h..t0
  row_t rows [7] = '{
    '{8'h00, 6'h00, 48'h00_08_00_08_08_08},
    '{8'h01, 6'h00, 48'h00_08_00_08_18_18},
    '{8'h02, 6'h00, 48'h00_08_00_08_18_18},
    '{8'h03, 6'h3C, 48'h02_02_02_02_02_02},
    '{8'hFC, 6'h0C, 48'h60_60_60_60_60_60},
    '{8'h0C, 6'h03, 48'h00_08_00_08_00_00},
    '{8'hA0, 6'h00, 48'h00_08_00_08_08_08}
  };

  timer_clock_select u_timer_clock_select (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .timer0_counter_sel_i(cfg[0]), .timer1_counter_sel_i(cfg[1]),
    .timer2_split_i(cfg[2]), .timer3_split_i(cfg[3]), .timer2_ext_clk_choice_i(cfg[4]),
    .timer3_ext_clk_choice_i(cfg[5]), .timer0_pin_i(pin0), .timer1_pin_i(pin1),
    .ext_clk_i(ext_clk), .timer0_tick_o(ticks[0]), .timer1_tick_o(ticks[1]),
    .timer2_low_tick_o(ticks[2]), .timer2_high_tick_o(ticks[3]),
    .timer3_low_tick_o(ticks[4]), .timer3_high_tick_o(ticks[5]), .clk_sel_o(clk_sel_o));

  timer_bank_model u_timer_bank_model (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clear_i(clr), .tick_i(ticks),
    .count_o(counts));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // External clock of 48 ns period, three system clocks per level
  initial begin
    ext_clk = 1'b0;
    #3;
    forever #24 ext_clk = ~ext_clk;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b0;
    #1;
    check("read data", exp, reg_rdata_o);
    @(posedge clk_sys_i);
    #1;
    check("read data idle", 8'h00, reg_rdata_o);
  endtask : reg_read

  // Clears the tick counters, then lets them run for the given cycles
  task automatic count_window(input int n);
    @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : count_window

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    end_sim();
  end

  initial begin
    reset_n_i = 1'b0; reg_we_i = 1'b0; reg_re_i = 1'b0; reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00; cfg = 6'h00; clr = 1'b0; pin0 = 1'b1; pin1 = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    reg_read(8'h8E, 8'h00);
    for (int r = 0; r < 7; r++) begin
      reg_write(8'h8E, rows[r].ctrl);
      cfg <= rows[r].cfg;
      repeat (3) @(posedge clk_sys_i);
      count_window(96);
      for (int k = 0; k < 6; k++) begin
        check($sformatf("row %0d t%0d", r, k), rows[r].exp[k], counts[k]);
      end
    end
    // Register port: read back, unmapped and read-only addresses ignored
    reg_write(8'h8E, 8'h5A);
    reg_read(8'h8E, 8'h5A);
    reg_write(8'h8F, 8'hFF);
    reg_write(8'h9E, 8'hFF);
    reg_read(8'h8F, 8'h00);
    // Status: timer 0 on prescaler, timers 1 to 3 on the system clock
    reg_read(8'h9E, 8'h01);
    check("clock select register", 8'h5A, clk_sel_o);
    // Pin event counting overrides the system clock select
    reg_write(8'h8E, 8'h0C);
    cfg <= 6'h03;
    repeat (3) @(posedge clk_sys_i);
    count_window(0);
    @(posedge clk_sys_i);
    for (int e = 0; e < 5; e++) begin
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
    end
    repeat (8) @(posedge clk_sys_i);
    #1;
    check("timer 0 pin events", 8'h05, counts[0]);
    check("timer 1 pin events", 8'h05, counts[1]);
    // Status: timers 0 and 1 on pin events, timers 2 and 3 on their alternative clock
    reg_read(8'h9E, 8'h5F);
    // Reset in mid-run
    reg_write(8'h8E, 8'hFC);
    cfg <= 6'h0C;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    check("clock select in reset", 8'h00, clk_sel_o);
    check("ticks in reset", 8'h00, {2'h0, ticks});
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    reg_read(8'h8E, 8'h00);
    end_sim();
  end
endmodule : tb_timer_clock_select
`default_nettype wire
